/* File: test/sees_host.sv */
// Two-wire bus controller model that stands opposite the memory slave
`timescale 1ns/1ps
module sees_host (
    input wire logic clk, // System clock, all pin changes land on its fall
    input wire logic sda_line, // Resolved data line level
    output logic scl, // Bus clock, stands high between frames
    output logic sda_rel // High releases the data line, low pulls it low
);
    // Extra low-phase clocks, lets a scenario run the bus slowly
    int slow = 0;

    // Idle bus: clock high, data released to the pull-up
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Start, or repeated start when entered with the clock low
    task automatic start();
        tick(2);
        sda_rel = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_rel = 1'b0;
        tick(4);
        scl = 1'b0;
    endtask

    // Data rises while the clock is high
    task automatic stop();
        tick(2);
        sda_rel = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_rel = 1'b1;
        tick(8);
    endtask

    // Data moves mid-low only; the line is read at the end of the high phase
    task automatic bit_slot(input logic d, output logic q);
        tick(2 + slow);
        sda_rel = d;
        tick(2);
        scl = 1'b1;
        tick(4);
        q = sda_line;
        scl = 1'b0;
    endtask

    // Eight bits most significant first, then the slave's acknowledge slot
    task automatic send(input logic [7:0] b, output logic ack);
        logic q;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(b[i], q);
        end
        bit_slot(1'b1, q);
        ack = ~q;
    endtask

    // Releases the line for eight bits, then acks unless it is the last byte
    task automatic recv(input logic last, output logic [7:0] b);
        logic q;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(1'b1, q);
            b[i] = q;
        end
        bit_slot(last, q);
    endtask
endmodule

/* File: test/tb.sv */
// Self-checking testbench for the two-wire memory slave core
`timescale 1ns/1ps
`include "sees_defs.svh"
module tb;
    // Short write cycle keeps the run brief
    localparam int T_WR = 200;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [2:0] straps = 3'h5;
    logic wp = 1'b0;
    logic scl;
    logic sda_rel;
    // Select value of the small variant that shares the bus
    localparam logic [2:0] SEL_SMALL = 3'h3;
    logic sda_drive;
    logic sda_oe_n;
    logic wr_busy;
    logic sda_drive_small;
    logic sda_oe_n_small;
    logic wr_busy_small;
    logic [7:0] ref_mem [0:8191];
    int n_mismatch = 0;
    int compares = 0;
    // Pull-up wins unless any party (host or either slave) pulls low
    wire sda_line = sda_rel & (sda_oe_n | sda_drive) &
        (sda_oe_n_small | sda_drive_small);

    always #50 clk = ~clk;

    sees_host host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_rel(sda_rel));

    sees_core #(.LARGE_VARIANT(1'b1), .T_WR_CYCLES(T_WR)) dut (
        .clk(clk),
        .reset(reset),
        .scl(scl),
        .sda(sda_line),
        .device_select_straps(straps),
        .wp(wp),
        .sda_drive(sda_drive),
        .sda_oe_n(sda_oe_n),
        .wr_busy(wr_busy)
    );

    // Small variant on a fixed select value, so the address mask is exercised
    sees_core #(.LARGE_VARIANT(1'b0), .T_WR_CYCLES(T_WR)) dut_small (
        .clk(clk),
        .reset(reset),
        .scl(scl),
        .sda(sda_line),
        .device_select_straps(SEL_SMALL),
        .wp(wp),
        .sda_drive(sda_drive_small),
        .sda_oe_n(sda_oe_n_small),
        .wr_busy(wr_busy_small)
    );

    // Length of the latest self-timed cycle; the stop task ends after it has begun
    int busy_len = 0;
    logic busy_q = 1'b0;
    always @(negedge clk) begin
        busy_q <= wr_busy;
        if (wr_busy === 1'b1) begin
            busy_len <= (busy_q === 1'b1) ? busy_len + 1 : 1;
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Page write of n bytes; when ok, acks are checked and the expected image updated
    task automatic write_bytes(input logic [15:0] a, input int n, input logic [7:0] d0,
                               input logic ok);
        logic ack;
        host.start();
        host.send({`SEES_DEV_CODE, straps, 1'b0}, ack);
        if (ok) check({7'h0, ack}, 8'h01);
        host.send(a[15:8], ack);
        host.send(a[7:0], ack);
        for (int i = 0; i < n; i++) begin
            host.send(d0 + 8'(i), ack);
            if (ok) check({7'h0, ack}, 8'h01);
            if (ok) ref_mem[{a[12:5], 5'(a[4:0] + 5'(i))}] = d0 + 8'(i);
        end
        host.stop();
    endtask

    // Bounded wait for the self-timed cycle, optionally checking its length
    task automatic wait_cycle(input logic chk);
        int len;
        len = 0;
        for (int i = 0; i < 20 && wr_busy !== 1'b1; i++) @(negedge clk);
        if (chk) check({7'h0, wr_busy}, 8'h01);
        while (wr_busy === 1'b1 && len < T_WR + 50) begin
            @(negedge clk);
            len++;
        end
        if (chk) check(8'(busy_len), 8'(T_WR));
    endtask

    // Random read of n bytes; the address wraps at the end of the array
    task automatic read_check(input logic [15:0] a, input int n);
        logic ack;
        logic [7:0] b;
        host.start();
        host.send({`SEES_DEV_CODE, straps, 1'b0}, ack);
        host.send(a[15:8], ack);
        host.send(a[7:0], ack);
        host.start();
        host.send({`SEES_DEV_CODE, straps, 1'b1}, ack);
        check({7'h0, ack}, 8'h01);
        for (int i = 0; i < n; i++) begin
            host.recv(i == n - 1, b);
            check(b, ref_mem[13'(a + 16'(i))]);
        end
        host.stop();
    endtask

    // Single byte, then polling during the cycle must be refused
    task automatic t_busy_poll();
        logic ack;
        write_bytes(16'h0000, 1, 8'h5a, 1'b1);
        host.start();
        host.send({`SEES_DEV_CODE, straps, 1'b0}, ack);
        check({7'h0, ack}, 8'h00);
        host.stop();
        wait_cycle(1'b0);
        write_bytes(16'h0123, 3, 8'h71, 1'b1);
        wait_cycle(1'b1);
        read_check(16'h0123, 3);
    endtask

    // Slow bus, 33 bytes roll over within the page, high address bits ignored
    task automatic t_page_wrap();
        host.slow = 3;
        write_bytes(16'hffe1, 33, 8'h10, 1'b1);
        host.slow = 0;
        wait_cycle(1'b1);
        read_check(16'h1fe0, 32);
        read_check(16'h1fff, 2);
    endtask

    // Only a matching device code and select value is acknowledged
    task automatic t_select();
        logic ack;
        logic hit;
        for (int k = 0; k < 2; k++) begin
            straps = k ? 3'h2 : 3'h5;
            host.tick(4);
            for (int s = 0; s < 9; s++) begin
                host.start();
                host.send({s < 8 ? `SEES_DEV_CODE : 4'hb, 3'(s), 1'b0}, ack);
                hit = s < 8 && (3'(s) == straps || 3'(s) == SEL_SMALL);
                check({7'h0, ack}, {7'h0, hit});
                host.stop();
            end
        end
        straps = 3'h5;
        host.tick(4);
    endtask

    // Write protect raised first: contents kept, reads still served
    task automatic t_protect();
        wp = 1'b1;
        host.tick(4);
        write_bytes(16'h0123, 2, 8'hc3, 1'b0);
        wait_cycle(1'b0);
        read_check(16'h0123, 3);
        wp = 1'b0;
        host.tick(4);
    endtask

    // Small variant: word address bit 12 is dropped, so 1045h lands on 0045h
    task automatic t_small();
        logic ack;
        logic [7:0] b;
        host.start();
        host.send({`SEES_DEV_CODE, SEL_SMALL, 1'b0}, ack);
        check({7'h0, ack}, 8'h01);
        host.send(8'h10, ack);
        host.send(8'h45, ack);
        host.send(8'h3c, ack);
        check({7'h0, ack}, 8'h01);
        host.stop();
        check({7'h0, wr_busy_small}, 8'h01);
        for (int i = 0; i < T_WR + 50 && wr_busy_small === 1'b1; i++) @(negedge clk);
        check({7'h0, wr_busy_small}, 8'h00);
        host.start();
        host.send({`SEES_DEV_CODE, SEL_SMALL, 1'b0}, ack);
        host.send(8'h00, ack);
        host.send(8'h45, ack);
        host.start();
        host.send({`SEES_DEV_CODE, SEL_SMALL, 1'b1}, ack);
        check({7'h0, ack}, 8'h01);
        host.recv(1'b1, b);
        check(b, 8'h3c);
        host.stop();
    endtask

    task automatic end_of_test();
        if (n_mismatch == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (8) @(negedge clk);
        reset = 1'b0;
        repeat (8) @(negedge clk);
        t_busy_poll();
        t_page_wrap();
        t_select();
        t_protect();
        t_small();
        end_of_test();
    end

    // Watchdog well beyond the expected run of some 12300 clocks
    initial begin
        #6000000;
        n_mismatch++;
        end_of_test();
    end
endmodule

/* File: verilog/sees_core.sv */
// Two-wire serial nonvolatile memory slave core
// Summary of operation
// R1: Sample data on bus clock rise, change outgoing data on bus clock fall.
// R2: Data line is only pulled low or released, never driven high.
// R3: Three strap inputs give a select value, up to eight devices per bus.
// R4: Floating select straps read as zero through a pad pull-down.
// R5: Write-protect low lets array writes proceed normally.
// R6: Write-protect high blocks every array write; reads still work.
// R7: Floating write-protect reads low, so writes are allowed by default.
// R8: Host raises write-protect before the write it wants blocked begins.
// R9: Small variant holds 128 pages of 32 bytes, 12-bit word address.
// R10: Large variant holds 256 pages of 32 bytes, 13-bit word address.
// R11: Each location holds one byte; bytes move serially one at a time.
// R12: Page writes up to 32 bytes; partial pages program only received bytes.
// R13: After stop, programming is self-timed and ends within 5 ms.
// R14: Data falling with clock high is start; rising with clock high is stop.
// R15: Host changes data only while clock low, except start and stop.
// R16: Device pulls data low in ninth clock after every received byte.
// R17: Respond only when select bits in the addressing byte match the straps.
// R18: Word-address bits above 12 or 13 are ignored per variant.
`timescale 1ns/1ps
`include "sees_defs.svh"
module sees_core import sees_pkg::*; #(
    parameter bit LARGE_VARIANT = 1'b1, // 1: 8192 bytes, 0: 4096 bytes
    parameter int T_WR_CYCLES = `SEES_T_WR_CYC // Self-timed write length
) (
    input wire logic clk, // 10 MHz system clock
    input wire logic reset, // Synchronous, active high
    input wire logic scl, // Bus clock pin
    input wire logic sda, // Data line level
    input wire logic [2:0] device_select_straps, // Select straps
    input wire logic wp, // Write protect, high blocks writes
    output logic sda_drive, // Data pin drive value, always low
    output logic sda_oe_n, // Low while pulling data line low
    output logic wr_busy // Internal programming in progress
);
    localparam logic [`SEES_TMR_W-1:0] TMR_LAST = `SEES_TMR_W'(T_WR_CYCLES - 1);
    localparam logic [`SEES_AW-1:0] ADDR_MASK = // R9 R10
        LARGE_VARIANT ? `SEES_LARGE_MASK : `SEES_SMALL_MASK;

    sees_regs_t s, n;
    sees_memreq_t mreq, preq;
    logic [7:0] mrdata, prdata;
    logic scl_rise, scl_fall, start_det, stop_det, rx_end;
    logic [`SEES_PAGE_BITS-1:0] pofs;

    // Addressing byte carries the device code and strap match
    function automatic logic sel_hit(input logic [7:0] b, input logic [2:0] sel);
        sel_hit = (b[7:4] == `SEES_DEV_CODE) && (b[3:1] == sel);
    endfunction

    // Order of received bytes after an addressing byte for writing
    function automatic sees_role_t role_after(input sees_role_t r);
        unique case (r)
            RL_CTRL: role_after = RL_ADRH;
            RL_ADRH: role_after = RL_ADRL;
            RL_ADRL: role_after = RL_DATA;
            RL_DATA: role_after = RL_DATA;
        endcase
    endfunction

    // Bus events seen on synchronised samples only
    assign scl_rise = s.scl_s & ~s.scl_p; // R1
    assign scl_fall = ~s.scl_s & s.scl_p; // R1
    assign start_det = s.scl_s & s.scl_p & s.sda_p & ~s.sda_s; // R14
    assign stop_det = s.scl_s & s.scl_p & ~s.sda_p & s.sda_s; // R14
    assign rx_end = scl_fall && (s.state == ST_RX) && (s.bits == `SEES_BYTE_BITS);
    assign pofs = `SEES_PAGE_BITS'(s.pidx - 6'h01);

    // Array of the full large size; the small variant masks the top bit
    sees_mem #(
        .AW(`SEES_AW)
    ) u_array (
        .clk(clk),
        .req(mreq),
        .rdata_ff(mrdata)
    );

    // Page buffer holds write bytes until the stop condition
    sees_mem #(
        .AW(`SEES_PAGE_BITS)
    ) u_page (
        .clk(clk),
        .req(preq),
        .rdata_ff(prdata)
    );

    // Next state of the whole slave
    always_comb begin
        n = s;
        mreq = '0;
        preq = '0;
        // Two-stage synchronisers for every pin input
        n.scl_m = scl;
        n.scl_s = s.scl_m;
        n.scl_p = s.scl_s;
        n.sda_m = sda;
        n.sda_s = s.sda_m;
        n.sda_p = s.sda_s;
        n.wp_m = wp;
        n.wp_s = s.wp_m;
        n.sel_m = device_select_straps; // R3
        n.sel_s = s.sel_m;
        n.sda_o = 1'b0; // R2
        // Read port follows the current address so data waits ready
        mreq.addr = s.addr & ADDR_MASK; // R18
        preq.addr = `SEES_AW'(s.pidx[`SEES_PAGE_BITS-1:0]);
        if (start_det && s.state != ST_PROG) begin
            // A repeated start drops any bytes not yet committed
            n.state = ST_RX; // R14
            n.role = RL_CTRL;
            n.bits = 4'h0;
            n.oe_n = 1'b1;
            n.valid = '0;
        end else if (stop_det && s.state != ST_PROG) begin
            n.oe_n = 1'b1;
            n.state = ST_IDLE;
            if (s.valid != '0 && !s.wp_lat && !s.wp_s) begin
                n.state = ST_PROG; // R5 R13
                n.pidx = 6'h00;
                n.tmr = '0;
            end else begin
                n.valid = '0; // R6
            end
        end else begin
            unique case (s.state)
                ST_IDLE: begin
                    n.oe_n = 1'b1;
                end
                ST_RX: begin
                    if (scl_rise) begin
                        n.shreg = {s.shreg[6:0], s.sda_s}; // R1 R11
                        n.bits = s.bits + 4'h1;
                    end else if (rx_end) begin
                        n.state = ST_ACK;
                        n.oe_n = 1'b0; // R16
                        unique case (s.role)
                            RL_CTRL: begin
                                if (sel_hit(s.shreg, s.sel_s)) begin
                                    n.rd = s.shreg[0];
                                    n.wp_lat = s.wp_s; // R8
                                end else begin
                                    n.state = ST_IDLE; // R17
                                    n.oe_n = 1'b1;
                                end
                            end
                            RL_ADRH: n.addr[`SEES_AW-1:8] = s.shreg[`SEES_AW-9:0];
                            RL_ADRL: n.addr[7:0] = s.shreg;
                            RL_DATA: begin
                                // Pointer wraps inside the page, as the page ends
                                preq.we = 1'b1; // R12
                                preq.addr = `SEES_AW'(s.addr[`SEES_PAGE_BITS-1:0]);
                                preq.wdata = s.shreg;
                                n.valid[s.addr[`SEES_PAGE_BITS-1:0]] = 1'b1;
                                n.addr[`SEES_PAGE_BITS-1:0] =
                                    s.addr[`SEES_PAGE_BITS-1:0] + `SEES_PAGE_BITS'(1);
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        n.oe_n = 1'b1;
                        n.bits = 4'h0;
                        if (s.rd) begin
                            n.state = ST_TX;
                            n.shreg = mrdata;
                            n.oe_n = mrdata[7]; // R1 R2
                            n.addr = (s.addr + `SEES_AW'(1)) & ADDR_MASK;
                        end else begin
                            n.state = ST_RX;
                            n.role = role_after(s.role);
                        end
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        n.bits = s.bits + 4'h1;
                    end else if (scl_fall) begin
                        if (s.bits == `SEES_BYTE_BITS) begin
                            n.state = ST_MACK;
                            n.oe_n = 1'b1;
                        end else begin
                            n.shreg = {s.shreg[6:0], 1'b0};
                            n.oe_n = s.shreg[6]; // R1 R11
                        end
                    end
                end
                ST_MACK: begin
                    // Host low in the ninth clock asks for another byte
                    if (scl_rise) begin
                        n.more = ~s.sda_s;
                    end else if (scl_fall) begin
                        n.bits = 4'h0;
                        if (s.more) begin
                            n.state = ST_TX;
                            n.shreg = mrdata;
                            n.oe_n = mrdata[7];
                            n.addr = (s.addr + `SEES_AW'(1)) & ADDR_MASK;
                        end else begin
                            n.state = ST_IDLE;
                        end
                    end
                end
                ST_PROG: begin
                    // Bus ignored: no answer until the write cycle ends
                    n.oe_n = 1'b1;
                    if (s.pidx != `SEES_PIDX_DONE) begin
                        n.pidx = s.pidx + 6'h01;
                    end
                    if (s.pidx != 6'h00 && s.pidx <= `SEES_PIDX_LAST) begin
                        mreq.we = s.valid[pofs]; // R12
                        mreq.addr = {s.addr[`SEES_AW-1:`SEES_PAGE_BITS], pofs} & ADDR_MASK;
                        mreq.wdata = prdata;
                    end
                    n.tmr = s.tmr + `SEES_TMR_W'(1);
                    if (s.tmr == TMR_LAST) begin
                        n.state = ST_IDLE; // R13
                        n.valid = '0;
                    end
                end
            endcase
        end
        n.busy = (n.state == ST_PROG);
    end

    // State register; straps and protect sync to zero, like the pad pull-downs
    always_ff @(posedge clk) begin
        if (reset) begin
            s <= '{state: ST_IDLE, role: RL_CTRL, oe_n: 1'b1,
                   scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1,
                   sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1,
                   default: '0}; // R4 R7
        end else begin
            s <= n;
        end
    end

    assign sda_drive = s.sda_o;
    assign sda_oe_n = s.oe_n;
    assign wr_busy = s.busy;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // Pin drive is never high and the line is free when idle or busy
    property p_open_drain;
        (s.state == ST_IDLE || s.state == ST_PROG) |-> (sda_oe_n && !sda_drive);
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("data line held while idle"); // R2

    property p_change_on_fall;
        $changed(sda_oe_n) |-> $past(scl_fall || start_det || stop_det);
    endproperty
    a_change_on_fall: assert property (p_change_on_fall) else $error("drive changed off edge"); // R1

    property p_sample_rise;
        (scl_rise && s.state == ST_RX && !start_det && !stop_det)
            |=> (s.shreg[0] == $past(s.sda_s)) && (s.bits == $past(s.bits) + 4'h1);
    endproperty
    a_sample_rise: assert property (p_sample_rise) else $error("bit not taken on rise"); // R11

    sequence s_hit;
        rx_end && !start_det && !stop_det && (s.role != RL_CTRL || sel_hit(s.shreg, s.sel_s));
    endsequence
    property p_ack;
        s_hit |=> (!sda_oe_n && s.state == ST_ACK);
    endproperty
    a_ack: assert property (p_ack) else $error("missing acknowledge"); // R16

    property p_miss;
        (rx_end && !start_det && !stop_det && s.role == RL_CTRL && !sel_hit(s.shreg, s.sel_s))
            |=> (sda_oe_n && s.state == ST_IDLE) [*2];
    endproperty
    a_miss: assert property (p_miss) else $error("answered foreign select"); // R17

    property p_start;
        (start_det && s.state != ST_PROG) |=> (s.state == ST_RX && s.role == RL_CTRL && sda_oe_n);
    endproperty
    a_start: assert property (p_start) else $error("start not seen"); // R14

    property p_protect;
        (stop_det && s.state != ST_PROG && (s.wp_s || s.wp_lat)) |=> !wr_busy;
    endproperty
    a_protect: assert property (p_protect) else $error("write under protect"); // R6

    property p_commit;
        (stop_det && s.state != ST_PROG && !s.wp_s && !s.wp_lat && s.valid != '0) |=> wr_busy;
    endproperty
    a_commit: assert property (p_commit) else $error("page not committed"); // R5

    property p_we_busy;
        mreq.we |-> (s.state == ST_PROG && s.valid[pofs]);
    endproperty
    a_we_busy: assert property (p_we_busy) else $error("array write outside cycle"); // R12

    property p_cycle_len;
        $fell(wr_busy) |-> ($past(s.tmr) == TMR_LAST);
    endproperty
    a_cycle_len: assert property (p_cycle_len) else $error("write cycle length wrong"); // R13

    property p_mask;
        !LARGE_VARIANT |-> !mreq.addr[`SEES_TOP_BIT];
    endproperty
    a_mask: assert property (p_mask) else $error("small variant top bit used"); // R18
endmodule

/* File: verilog/sees_defs.svh */
// Constants of the two-wire serial nonvolatile memory slave
`ifndef SEES_DEFS_SVH
`define SEES_DEFS_SVH
`define SEES_AW 13
`define SEES_PAGE_BITS 5
`define SEES_SMALL_MASK 13'h0fff
`define SEES_LARGE_MASK 13'h1fff
`define SEES_TOP_BIT 12
`define SEES_DEV_CODE 4'ha
`define SEES_BYTE_BITS 4'h8
`define SEES_PIDX_LAST 6'h20
`define SEES_PIDX_DONE 6'h21
`define SEES_CLK_HZ 10000000
`define SEES_T_WR_MS 5
`define SEES_T_WR_CYC ((`SEES_T_WR_MS * `SEES_CLK_HZ) / 1000)
`define SEES_TMR_W 20
`endif

/* File: verilog/sees_mem.sv */
// Byte-wide synchronous memory with registered read data
`timescale 1ns/1ps
`include "sees_defs.svh"
module sees_mem import sees_pkg::*; #(
    parameter int AW = `SEES_AW
) (
    input wire logic clk, // System clock
    input wire sees_memreq_t req, // Write strobe, address, data
    output logic [7:0] rdata_ff // Byte at last cycle's address
);
    logic [7:0] ram [0:(1<<AW)-1];

    // Old data is read when a write hits the same address
    always_ff @(posedge clk) begin
        if (req.we) begin
            ram[req.addr[AW-1:0]] <= req.wdata;
        end
        rdata_ff <= ram[req.addr[AW-1:0]];
    end
endmodule

/* File: verilog/sees_pkg.sv */
// Types shared by the memory slave core and its storage
package sees_pkg;
`include "sees_defs.svh"

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_RX = 6'h02,
        ST_ACK = 6'h04,
        ST_TX = 6'h08,
        ST_MACK = 6'h10,
        ST_PROG = 6'h20
    } sees_state_t;

    typedef enum logic [3:0] {
        RL_CTRL = 4'h1,
        RL_ADRH = 4'h2,
        RL_ADRL = 4'h4,
        RL_DATA = 4'h8
    } sees_role_t;

    typedef struct packed {
        logic we;
        logic [`SEES_AW-1:0] addr;
        logic [7:0] wdata;
    } sees_memreq_t;

    typedef struct packed {
        logic scl_m, scl_s, scl_p;
        logic sda_m, sda_s, sda_p;
        logic wp_m, wp_s;
        logic [2:0] sel_m, sel_s;
        sees_state_t state;
        sees_role_t role;
        logic [3:0] bits;
        logic [7:0] shreg;
        logic rd;
        logic more;
        logic wp_lat;
        logic [`SEES_AW-1:0] addr;
        logic [31:0] valid;
        logic [5:0] pidx;
        logic [`SEES_TMR_W-1:0] tmr;
        logic oe_n;
        logic sda_o;
        logic busy;
    } sees_regs_t;
endpackage
